// ---- logic/sw_glob_pkg.sv ----
/*
  Package for the switch global control register bank: offsets, field positions,
  reset values, aging timing constants and the carrier structs.
  Assumes a 16-bit host register port with byte enables, clocked with the switch.
*/
package sw_glob_pkg;
  // register offsets in the host byte address space
  localparam logic [7:0] OFS_CTRL_ONE = 8'h02;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;

  // first register field positions
  localparam int BIT_LEN_CHECK = 11;
  localparam int BIT_AGE_EN = 10;
  localparam int BIT_FAST_AGE = 9;
  localparam int BIT_AGGR_BACKOFF = 8;
  localparam int BIT_RATE_FC = 5;
  localparam int BIT_RX_2K = 4;
  localparam int BIT_PASS_FC = 3;
  localparam int BIT_LINK_AGE = 0;
  // second register field positions
  localparam int BIT_VLAN_EN = 15;
  localparam int BIT_IGMP_EN = 14;
  localparam int BIT_MLD_EN = 13;

  // reset values and writable masks of the bits owned here
  localparam logic [15:0] RST_CTRL_ONE = 16'h0450; // aging, 2K on; reserved 7:6 = 01
  localparam logic [15:0] MASK_CTRL_ONE = 16'h0FFF;
  localparam logic [15:0] RST_CTRL_TWO = 16'h0000;
  localparam logic [15:0] MASK_CTRL_TWO = 16'hE000;

  // frame length limits
  localparam logic [10:0] LEN_TYPE_LIMIT = 11'h5DC; // 1500
  localparam logic [11:0] MAX_LEN_NO_2K = 12'h7D0; // 2000

  // aging timing
  localparam int CLK_HZ = 50_000_000;
  localparam int FAST_AGE_US = 800;
  localparam int NORMAL_AGE_S = 300;
  localparam int NORMAL_AGE_JITTER_S = 75;
  localparam int FAST_AGE_CYC = FAST_AGE_US * (CLK_HZ / 1_000_000); // longest, rounds down
  localparam longint NORMAL_AGE_CYC =
    longint'(NORMAL_AGE_S + NORMAL_AGE_JITTER_S) * longint'(CLK_HZ);

  // host register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } reg_req_t;

  // control levels to the datapath and aging logic
  typedef struct packed {
    logic len_check;
    logic age_en;
    logic fast_age;
    logic aggr_backoff;
    logic rate_fc;
    logic rx_2k;
    logic pass_fc;
    logic link_age;
    logic vlan_en;
    logic igmp_en;
    logic mld_en;
  } ctrl_t;
endpackage : sw_glob_pkg

// ---- logic/age_timer.sv ----
/*
  Aging tick generator: emits a sweep pulse for the address table at the
  normal or fast period, plus one-shot fast sweeps and flush on link loss.
  Assumes link_lost is a one-cycle pulse in the clk domain.
*/
`timescale 1ns/1ps
module age_timer #(
  parameter longint NORMAL_CYC = sw_glob_pkg::NORMAL_AGE_CYC,
  parameter int FAST_CYC = sw_glob_pkg::FAST_AGE_CYC
) (
  input wire logic clk, // switch clock
  input wire logic srst, // sync reset
  input wire logic ce, // clock enable
  input wire logic age_en, // aging allowed
  input wire logic fast_age, // fast period always
  input wire logic link_age, // fast sweep after link loss
  input wire logic link_lost, // any port link to no link
  output logic sweep_r, // age one pass of the table
  output logic flush_r // age out every entry
);
  logic [39:0] cnt_r, cnt_nxt;
  logic oneshot_r, oneshot_nxt;
  logic sweep_nxt, flush_nxt;
  logic fast;

  // count toward the active period; a pending one-shot forces the fast period
  always_comb
  begin
    fast = fast_age | oneshot_r;
    cnt_nxt = cnt_r + 40'h1;
    oneshot_nxt = oneshot_r;
    sweep_nxt = 1'b0;
    flush_nxt = link_lost; // cable loss clears the table regardless of aging
    if (link_lost && link_age)
      oneshot_nxt = 1'b1;
    if (!age_en)
    begin
      cnt_nxt = 40'h0; // no periodic sweeps while disabled
    end
    else if ((fast && cnt_r >= 40'(FAST_CYC - 1)) || cnt_r >= 40'(NORMAL_CYC - 1))
    begin
      cnt_nxt = 40'h0;
      sweep_nxt = 1'b1;
      if (!(link_lost && link_age))
        oneshot_nxt = 1'b0; // back to normal period after one fast cycle
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_r <= 40'h0;
      oneshot_r <= 1'b0;
      sweep_r <= 1'b0;
      flush_r <= 1'b0;
    end
    else if (ce)
    begin
      cnt_r <= cnt_nxt;
      oneshot_r <= oneshot_nxt;
      sweep_r <= sweep_nxt;
      flush_r <= flush_nxt;
    end
  end
endmodule : age_timer

// ---- logic/switch_global_control.sv ----
/*
  Global switch control bank: the two global control registers, their effect
  on frame admission and flow control, and the address table aging tick.
  Assumes a 16-bit register port with byte enables and per-frame descriptors
  presented by the receive datapath for one cycle.
*/
`timescale 1ns/1ps
module switch_global_control #(
  parameter longint NORMAL_CYC = sw_glob_pkg::NORMAL_AGE_CYC,
  parameter int FAST_CYC = sw_glob_pkg::FAST_AGE_CYC,
  parameter int PORTS = 2
) (
  input wire logic clk, // switch clock
  input wire logic srst, // sync reset, active high
  input wire logic ce, // clock enable
  input wire sw_glob_pkg::reg_req_t req, // host register access
  output logic [15:0] rdata_r, // read data
  output logic rvalid_r, // read data valid
  input wire logic [PORTS-1:0] link_up, // per-port link status
  input wire logic frm_valid, // frame descriptor valid
  input wire logic [11:0] frm_len, // frame length in bytes
  input wire logic [15:0] frm_len_type, // length/type field
  input wire logic [11:0] frm_payload, // actual payload length
  input wire logic frm_is_pause, // frame is flow control
  input wire logic frm_over_rate, // port over ingress limit
  input wire logic frm_size_drop, // size check from second reg bits 2,1
  output logic frm_done_r, // decision valid
  output logic frm_drop_r, // discard frame
  output logic frm_send_pause_r, // send flow control to partner
  output sw_glob_pkg::ctrl_t ctrl_r, // control levels
  output logic sweep_r, // age one table pass
  output logic flush_r // age out all entries
);
  logic [15:0] one_r, one_nxt, two_r, two_nxt;
  logic [15:0] rdata_nxt;
  logic rvalid_nxt;
  logic [PORTS-1:0] link_d_r, link_d_nxt;
  logic link_lost_r, link_lost_nxt;
  logic done_nxt, drop_nxt, pause_nxt;
  logic len_bad, size_bad, fc_filter, rate_drop;
  sw_glob_pkg::ctrl_t ctrl_nxt;

  // byte-lane merge of a write, keeping bits that this bank does not own
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [1:0] be, input logic [15:0] mask);
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & mask;
    merge = (old & ~lane) | (wd & lane);
  endfunction : merge

  // register pair to control levels; shared by the live path and the reset value
  function automatic sw_glob_pkg::ctrl_t decode(input logic [15:0] one, input logic [15:0] two);
    sw_glob_pkg::ctrl_t c;
    c.len_check = one[sw_glob_pkg::BIT_LEN_CHECK];
    c.age_en = one[sw_glob_pkg::BIT_AGE_EN];
    c.fast_age = one[sw_glob_pkg::BIT_FAST_AGE];
    c.aggr_backoff = one[sw_glob_pkg::BIT_AGGR_BACKOFF];
    c.rate_fc = one[sw_glob_pkg::BIT_RATE_FC];
    c.rx_2k = one[sw_glob_pkg::BIT_RX_2K];
    c.pass_fc = one[sw_glob_pkg::BIT_PASS_FC];
    c.link_age = one[sw_glob_pkg::BIT_LINK_AGE];
    c.vlan_en = two[sw_glob_pkg::BIT_VLAN_EN];
    c.igmp_en = two[sw_glob_pkg::BIT_IGMP_EN];
    c.mld_en = two[sw_glob_pkg::BIT_MLD_EN];
    decode = c;
  endfunction : decode

  // levels out of reset match the reset registers, so users never see a zero gap
  localparam sw_glob_pkg::ctrl_t CTRL_RST = decode(sw_glob_pkg::RST_CTRL_ONE,
                                                   sw_glob_pkg::RST_CTRL_TWO);

  // register writes and reads; second-register bits outside 15:13 keep their value, first-register reserved 7:6 take what is written
  always_comb
  begin
    one_nxt = one_r;
    two_nxt = two_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    if (req.wr)
    begin
      case (req.addr)
        sw_glob_pkg::OFS_CTRL_ONE:
          one_nxt = merge(one_r, req.wdata, req.be, sw_glob_pkg::MASK_CTRL_ONE);
        sw_glob_pkg::OFS_CTRL_TWO:
          two_nxt = merge(two_r, req.wdata, req.be, sw_glob_pkg::MASK_CTRL_TWO);
        default: one_nxt = one_r; // other offsets belong to other banks
      endcase
    end
    if (req.rd)
    begin
      rvalid_nxt = 1'b1;
      case (req.addr)
        sw_glob_pkg::OFS_CTRL_ONE: rdata_nxt = one_r;
        sw_glob_pkg::OFS_CTRL_TWO: rdata_nxt = two_r;
        default: rdata_nxt = 16'h0000; // unmapped reads as zero
      endcase
    end
  end

  // control levels follow the registers live, no restart needed
  always_comb
  begin
    ctrl_nxt = decode(one_nxt, two_nxt);
  end

  // per-frame admission using current register values
  always_comb
  begin
    len_bad = 1'b0;
    size_bad = 1'b0;
    fc_filter = 1'b0;
    rate_drop = 1'b0;
    done_nxt = frm_valid;
    drop_nxt = 1'b0;
    pause_nxt = 1'b0;
    if (frm_valid)
    begin
      // only length-typed frames are checked; type values pass untouched
      len_bad = one_r[sw_glob_pkg::BIT_LEN_CHECK] &&
                frm_len_type < 16'(sw_glob_pkg::LEN_TYPE_LIMIT) &&
                frm_len_type != 16'(frm_payload);
      // with 2K receive on, the second-register size verdict is ignored
      if (!one_r[sw_glob_pkg::BIT_RX_2K])
        size_bad = (frm_len > sw_glob_pkg::MAX_LEN_NO_2K) || frm_size_drop;
      fc_filter = frm_is_pause && !one_r[sw_glob_pkg::BIT_PASS_FC];
      rate_drop = frm_over_rate && !one_r[sw_glob_pkg::BIT_RATE_FC];
      pause_nxt = frm_over_rate && one_r[sw_glob_pkg::BIT_RATE_FC];
      drop_nxt = len_bad || size_bad || fc_filter || rate_drop;
    end
  end

  // link-down edge detect; link_up is taken as synchronous
  always_comb
  begin
    link_d_nxt = link_up;
    link_lost_nxt = |(link_d_r & ~link_up);
  end

  // register state and readback; ctrl_r loads from the next value, so a
  // write shows on ctrl_r at the same edge as it lands in the register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      one_r <= sw_glob_pkg::RST_CTRL_ONE;
      two_r <= sw_glob_pkg::RST_CTRL_TWO;
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
      ctrl_r <= CTRL_RST;
    end
    else if (ce)
    begin
      one_r <= one_nxt;
      two_r <= two_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  // frame verdict, one cycle behind the descriptor
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      frm_done_r <= 1'b0;
      frm_drop_r <= 1'b0;
      frm_send_pause_r <= 1'b0;
    end
    else if (ce)
    begin
      frm_done_r <= done_nxt;
      frm_drop_r <= drop_nxt;
      frm_send_pause_r <= pause_nxt;
    end
  end

  // link history cleared to all down, so leaving reset never fakes a loss
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      link_d_r <= '0;
      link_lost_r <= 1'b0;
    end
    else if (ce)
    begin
      link_d_r <= link_d_nxt;
      link_lost_r <= link_lost_nxt;
    end
  end

  // aging tick; flush on any link loss, one fast pass if enabled
  age_timer #(
    .NORMAL_CYC(NORMAL_CYC),
    .FAST_CYC(FAST_CYC)
  ) u_age (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .age_en(one_r[sw_glob_pkg::BIT_AGE_EN]),
    .fast_age(one_r[sw_glob_pkg::BIT_FAST_AGE]),
    .link_age(one_r[sw_glob_pkg::BIT_LINK_AGE]),
    .link_lost(link_lost_r),
    .sweep_r(sweep_r),
    .flush_r(flush_r)
  );
endmodule : switch_global_control

// ---- bench/sgc_chk.sv ----
/*
  Checker for the global control bank: frame verdicts, control bits, aging pulses.
  Assumes one clock domain, srst synchronous active high, bound to the top module.
*/
`timescale 1ns/1ps
module sgc_chk #(
  parameter int FAST_CYC = 20,
  parameter int PORTS = 2
) (
  input wire logic clk, // switch clock
  input wire logic srst, // sync reset
  input wire logic ce, // clock enable
  input wire sw_glob_pkg::reg_req_t req, // host access
  input wire logic [PORTS-1:0] link_up, // link levels
  input wire logic frm_valid, // descriptor valid
  input wire logic [11:0] frm_len, // frame length
  input wire logic [15:0] frm_len_type, // length/type field
  input wire logic [11:0] frm_payload, // payload length
  input wire logic frm_is_pause, // flow control frame
  input wire logic frm_over_rate, // over ingress limit
  input wire logic frm_done_r, // verdict valid
  input wire logic frm_drop_r, // discard
  input wire logic frm_send_pause_r, // pause out
  input wire sw_glob_pkg::ctrl_t ctrl_r, // control levels
  input wire logic sweep_r, // age pass
  input wire logic flush_r // age out all
);
  localparam int FW = FAST_CYC + 3; // slack for registered pulses
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // frame taken this edge
  wire f = frm_valid && ce;

  property p_len; f && ctrl_r.len_check && frm_len_type < 16'h05DC &&
    frm_len_type != {4'h0, frm_payload} |=> frm_drop_r; endproperty
  a_len: assert property (p_len) else $error("length mismatch kept");
  property p_big; f && !ctrl_r.rx_2k && frm_len > 12'h7D0 |=> frm_drop_r; endproperty
  a_big: assert property (p_big) else $error("long frame kept");
  property p_jumbo; f && ctrl_r.rx_2k && !ctrl_r.len_check && !frm_is_pause &&
    !frm_over_rate |=> frm_done_r && !frm_drop_r; endproperty
  a_jumbo: assert property (p_jumbo) else $error("2K frame dropped");
  property p_rate; f && frm_over_rate |=> frm_done_r &&
    frm_send_pause_r == $past(ctrl_r.rate_fc) && (frm_drop_r || frm_send_pause_r); endproperty
  a_rate: assert property (p_rate) else $error("rate excess wrong");
  property p_pause; f && frm_is_pause && !ctrl_r.pass_fc |=> frm_drop_r; endproperty
  a_pause: assert property (p_pause) else $error("pause frame passed");
  property p_one; ce && req.wr && req.addr == 8'h02 && req.be[1] |=> {ctrl_r.len_check,
    ctrl_r.age_en, ctrl_r.fast_age, ctrl_r.aggr_backoff} == $past(req.wdata[11:8]); endproperty
  a_one: assert property (p_one) else $error("reg one high bits");
  property p_two; ce && req.wr && req.addr == 8'h04 && req.be[1] |=>
    {ctrl_r.vlan_en, ctrl_r.igmp_en, ctrl_r.mld_en} == $past(req.wdata[15:13]); endproperty
  a_two: assert property (p_two) else $error("reg two bits");
  property p_noage; !ctrl_r.age_en && !$past(ctrl_r.age_en) |-> !sweep_r; endproperty
  a_noage: assert property (p_noage) else $error("sweep while off");
  property p_fast; sweep_r && ctrl_r.fast_age && ctrl_r.age_en |->
    ##[1:FW] (sweep_r || !ctrl_r.fast_age || !ctrl_r.age_en); endproperty
  a_fast: assert property (p_fast) else $error("fast period late");
  property p_flush; ce && |($past(link_up) & ~link_up) |-> ##[1:3] flush_r; endproperty
  a_flush: assert property (p_flush) else $error("no flush on loss");
  property p_link; flush_r && ctrl_r.link_age && ctrl_r.age_en |-> ##[1:FW] sweep_r; endproperty
  a_link: assert property (p_link) else $error("no fast sweep");
endmodule : sgc_chk

bind switch_global_control sgc_chk #(.FAST_CYC(FAST_CYC), .PORTS(PORTS)) chk (.*);

// ---- bench/tb.sv ----
/*
  Self-checking bench: register reads, random frame verdicts, link loss flushes.
  Assumes the checker file is compiled alongside and binds itself to the top.
*/
`timescale 1ns/1ps
module tb;
  logic clk = 0, srst = 1, ce = 1, frm_valid = 0, frm_is_pause = 0;
  logic frm_over_rate = 0, frm_size_drop = 0, rvalid_r, frm_done_r, frm_drop_r;
  logic frm_send_pause_r, sweep_r, flush_r;
  logic [1:0] link_up = 2'h3;
  logic [11:0] frm_len = 0, frm_payload = 0;
  logic [15:0] frm_len_type = 0, rdata_r, m1;
  sw_glob_pkg::reg_req_t req = '0;
  sw_glob_pkg::ctrl_t ctrl_r;
  logic [15:0] qr[$];
  logic [1:0] qf[$];
  int num_errors = 0, check_count = 0, nfl = 0;

  always #10 clk = ~clk;
  switch_global_control #(.NORMAL_CYC(200), .FAST_CYC(20)) DUT (.*);

  task automatic cmp_rd(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp_rd
  task automatic cmp_fr(input logic [1:0] g, input logic [1:0] e);
    cmp_rd({14'h0, g}, {14'h0, e});
  endtask : cmp_fr

  // results are paired with the oldest note; an unexpected one never matches
  always @(posedge clk)
  begin
    if (rvalid_r === 1'b1 && qr.size() == 0)
      num_errors++; // read answer nobody asked for
    else if (rvalid_r === 1'b1)
      cmp_rd(rdata_r, qr.pop_front());
    if (frm_done_r === 1'b1 && qf.size() == 0)
      num_errors++; // verdict for a frame never sent
    else if (frm_done_r === 1'b1)
      cmp_fr({frm_drop_r, frm_send_pause_r}, qf.pop_front());
    if (flush_r === 1'b1) nfl++;
  end

  task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    @(negedge clk) req = {2'b10, a, be, d};
    @(negedge clk) req = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    qr.push_back(e);
    @(negedge clk) req = {2'b01, a, 2'h3, 16'h0000};
    @(negedge clk) req = '0;
  endtask : rd
  // valid stays up between calls so frames go back to back
  task automatic fr();
    @(negedge clk);
    {frm_is_pause, frm_over_rate, frm_size_drop} = 3'($urandom);
    frm_len = 12'h7C0 + 12'($urandom % 32);
    frm_payload = 12'($urandom % 1600);
    frm_len_type = ($urandom % 2) ? {4'h0, frm_payload} : 16'($urandom % 1600);
    qf.push_back({(m1[11] && frm_len_type < 16'h05DC && frm_len_type != {4'h0, frm_payload})
      || (!m1[4] && (frm_len > 12'h7D0 || frm_size_drop)) || (frm_is_pause && !m1[3])
      || (frm_over_rate && !m1[5]), frm_over_rate && m1[5]});
    frm_valid = 1;
  endtask : fr

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // main sequence
  initial
  begin
    void'($urandom(32'h415A));
    repeat (3) @(negedge clk);
    srst = 0;
    rd(8'h02, 16'h0450);
    rd(8'h04, 16'h0000);
    rd(8'h06, 16'h0000);
    wr(8'h02, 2'h3, 16'hFFFF);
    rd(8'h02, 16'h0FFF);
    wr(8'h02, 2'h1, 16'h0000);
    rd(8'h02, 16'h0F00);
    wr(8'h04, 2'h3, 16'hFFFF);
    rd(8'h04, 16'hE000);
    wr(8'h04, 2'h2, 16'h0000);
    rd(8'h04, 16'h0000);
    // fast aging, then link loss with and without aging
    wr(8'h02, 2'h3, 16'h0600);
    repeat (300) @(negedge clk);
    wr(8'h02, 2'h3, 16'h0411);
    link_up = 2'h2;
    repeat (40) @(negedge clk);
    link_up = 2'h3;
    wr(8'h02, 2'h3, 16'h0011);
    link_up = 2'h1;
    repeat (40) @(negedge clk);
    cmp_rd(16'(nfl), 16'h0002);
    repeat (12)
    begin
      m1 = (16'($urandom) & 16'h0F39) | 16'h0040; // reserved bits as read back
      wr(8'h02, 2'h3, m1);
      // a write while ce is low must not land
      @(negedge clk) ce = 0;
      req = {2'b10, 8'h02, 2'h3, ~m1};
      @(negedge clk) req = '0;
      ce = 1;
      rd(8'h02, m1);
      repeat (6) fr();
      @(negedge clk) frm_valid = 0;
    end
    for (int i = 0; i < 50 && (qr.size() || qf.size()); i++) @(posedge clk);
    if (qr.size() || qf.size()) num_errors++;
    print_verdict();
  end
endmodule : tb
